// >>> core/scan_cell_pkg.sv
// Shared types and constants for the mux-scan storage cell family
package scan_cell_pkg;

	// ------------------------------------------------------------------
	// Variant selection
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		VARIANT_PLAIN  = 2'b00,
		VARIANT_CLEAR  = 2'b01,
		VARIANT_PRESET = 2'b10,
		VARIANT_BOTH   = 2'b11
	} variant_t;

	// ------------------------------------------------------------------
	// Per-bit input bundle
	// ------------------------------------------------------------------
	typedef struct packed {
		logic func_data;
		logic scan_data_in;
		logic test_path_pick;
	} cell_in_t;

	// ------------------------------------------------------------------
	// Levels and reset values
	// ------------------------------------------------------------------
	localparam logic     CLEAR_LEVEL     = 1'b0;
	localparam logic     PRESET_LEVEL    = 1'b1;
	localparam logic     PICK_FUNCTIONAL = 1'b0;
	localparam logic     PICK_SCAN       = 1'b1;
	localparam logic     CTRL_IDLE       = 1'b1;
	localparam logic     ILLEGAL_RST     = 1'b0;
	localparam int       SYNC_STAGES     = 2;
	localparam variant_t DEFAULT_VARIANT = VARIANT_BOTH;

endpackage : scan_cell_pkg

// >>> core/ctrl_pin_sync.sv
// Two-stage synchroniser for asynchronous control pins
`timescale 1ns/1ns

module ctrl_pin_sync #(
	parameter int         WIDTH    = 2,
	parameter logic [1:0] IDLE_VAL = 2'h3
) (
	input  wire logic             core_clk,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] pin_in,
	output logic      [WIDTH-1:0] pin_sync
);
	import scan_cell_pkg::*;

	logic [WIDTH-1:0] meta_q;

	if (WIDTH != 2) begin : g_bad_width
		$error("ctrl_pin_sync serves exactly two control pins");
	end

	// ------------------------------------------------------------------
	// Synchroniser chain
	// ------------------------------------------------------------------
	// First stage feeds only the second; nothing else may look at it
	always_ff @(posedge core_clk) begin
		if (rst) begin
			meta_q   <= IDLE_VAL;
			pin_sync <= IDLE_VAL;
		end else begin
			meta_q   <= pin_in;
			pin_sync <= meta_q;
		end
	end

endmodule // ctrl_pin_sync

// >>> core/mux_scan_flip_flop_family.sv
// Mux-scan edge-triggered storage cell family with optional clear/preset
`timescale 1ns/1ns

module mux_scan_flip_flop_family
	import scan_cell_pkg::*;
#(
	parameter scan_cell_pkg::variant_t VARIANT  = scan_cell_pkg::DEFAULT_VARIANT,
	parameter bit                      BUFFERED = 1'b0,
	parameter int                      WIDTH    = 1
) (
	input  wire logic                          core_clk,
	input  wire logic                          rst,
	input  wire scan_cell_pkg::cell_in_t [WIDTH-1:0] cell_in,
	input  wire logic                          async_clear_low,
	input  wire logic                          async_preset_low,
	output logic      [WIDTH-1:0]              true_out,
	output logic      [WIDTH-1:0]              inverted_out,
	output logic                               illegal_seen
);
	import scan_cell_pkg::*;

	// ------------------------------------------------------------------
	// Elaboration checks
	// ------------------------------------------------------------------
	if (WIDTH < 1) begin : g_bad_width
		$error("mux_scan_flip_flop_family needs WIDTH of at least one");
	end

	// ------------------------------------------------------------------
	// Variant decode
	// ------------------------------------------------------------------
	localparam bit HAS_CLEAR  = (VARIANT == VARIANT_CLEAR) || (VARIANT == VARIANT_BOTH);
	localparam bit HAS_PRESET = (VARIANT == VARIANT_PRESET) || (VARIANT == VARIANT_BOTH);

	// Unused controls are held idle so the variant sees only its own pins
	logic clear_low_eff;
	logic preset_low_eff;

	assign clear_low_eff  = HAS_CLEAR ? async_clear_low : CTRL_IDLE;
	assign preset_low_eff = HAS_PRESET ? async_preset_low : CTRL_IDLE;

	// ------------------------------------------------------------------
	// Selected capture value per bit
	// ------------------------------------------------------------------
	logic [WIDTH-1:0] pick_value;
	logic [WIDTH-1:0] cell_q;

	for (genvar b = 0; b < WIDTH; b++) begin : g_pick
		always_comb begin
			if (cell_in[b].test_path_pick == PICK_SCAN) begin
				pick_value[b] = cell_in[b].scan_data_in;
			end else begin
				pick_value[b] = cell_in[b].func_data;
			end
		end
	end

	// ------------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------------
	// Clear and preset act without the clock, as the cells do; the
	// synchronous rst deliberately leaves the stored state alone since
	// the cells have no synchronous reset of their own.
	for (genvar b = 0; b < WIDTH; b++) begin : g_store
		if (HAS_CLEAR && HAS_PRESET) begin : g_both
			// Both low is outside the contract; clear is given priority
			always_ff @(posedge core_clk or negedge clear_low_eff or negedge preset_low_eff) begin
				if (!clear_low_eff) begin
					cell_q[b] <= CLEAR_LEVEL;
				end else if (!preset_low_eff) begin
					cell_q[b] <= PRESET_LEVEL;
				end else begin
					cell_q[b] <= pick_value[b];
				end
			end
		end else if (HAS_CLEAR) begin : g_clear
			always_ff @(posedge core_clk or negedge clear_low_eff) begin
				if (!clear_low_eff) begin
					cell_q[b] <= CLEAR_LEVEL;
				end else begin
					cell_q[b] <= pick_value[b];
				end
			end
		end else if (HAS_PRESET) begin : g_preset
			always_ff @(posedge core_clk or negedge preset_low_eff) begin
				if (!preset_low_eff) begin
					cell_q[b] <= PRESET_LEVEL;
				end else begin
					cell_q[b] <= pick_value[b];
				end
			end
		end else begin : g_plain
			// Only the rising edge moves the value; nothing else is listened to
			always_ff @(posedge core_clk) begin
				cell_q[b] <= pick_value[b];
			end
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	assign true_out = cell_q;

	// Unbuffered variants have no complement pin; it reads low
	if (BUFFERED) begin : g_buffered
		assign inverted_out = ~cell_q;
	end else begin : g_unbuffered
		assign inverted_out = '0;
	end

	// ------------------------------------------------------------------
	// Illegal control combination monitor
	// ------------------------------------------------------------------
	// The pins are asynchronous, so they are synchronised before the monitor
	// logic looks at them. A short overlap below one cycle may be missed.
	logic [1:0] ctrl_sync;
	logic       illegal_seen_q;
	logic       illegal_seen_d;

	ctrl_pin_sync #(
		.WIDTH    (2),
		.IDLE_VAL (2'h3)
	) u_ctrl_sync (
		.core_clk (core_clk),
		.rst      (rst),
		.pin_in   ({clear_low_eff, preset_low_eff}),
		.pin_sync (ctrl_sync)
	);

	always_comb begin
		illegal_seen_d = illegal_seen_q;
		if (ctrl_sync == 2'h0) begin
			illegal_seen_d = 1'b1;
		end
	end

	// Sticky until rst; a new overlap in the rst cycle is not lost
	always_ff @(posedge core_clk) begin
		if (rst && ctrl_sync != 2'h0) begin
			illegal_seen_q <= ILLEGAL_RST;
		end else begin
			illegal_seen_q <= illegal_seen_d;
		end
	end

	assign illegal_seen = illegal_seen_q;

endmodule // mux_scan_flip_flop_family

// >>> sim/scan_env_model.sv
// Model of the surrounding logic that feeds one scan cell
`timescale 1ns/1ns

module scan_env_model
	import scan_cell_pkg::*;
(
	input  wire logic               func_bit,
	input  wire logic               scan_bit,
	input  wire logic               pick,
	input  wire logic               clear_req,
	input  wire logic               preset_req,
	input  wire logic               overlap_ok,
	output scan_cell_pkg::cell_in_t cell_word,
	output logic                    clear_low,
	output logic                    preset_low
);
	assign cell_word = {func_bit, scan_bit, pick};
	assign clear_low = ~clear_req;
	// Preset yields to clear; overlap only when a test orders it
	assign preset_low = ~(preset_req & (~clear_req | overlap_ok));
endmodule // scan_env_model

// >>> sim/scan_cell_chk.sv
// Port-level assertion checker for the scan cell
`timescale 1ns/1ns

module scan_cell_chk
	import scan_cell_pkg::*;
#(
	parameter bit BUFFERED = 1'b0,
	parameter int WIDTH    = 1
) (
	input wire logic                                 core_clk,
	input wire logic                                 rst,
	input wire scan_cell_pkg::cell_in_t [WIDTH-1:0] cell_in,
	input wire logic                                 async_clear_low,
	input wire logic                                 async_preset_low,
	input wire logic [WIDTH-1:0]                     true_out,
	input wire logic [WIDTH-1:0]                     inverted_out,
	input wire logic                                 illegal_seen
);
	logic ok;
	logic both;
	assign ok = async_clear_low & async_preset_low;
	assign both = ~async_clear_low & ~async_preset_low;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	a_func_capture: assert property (ok && !cell_in[0].test_path_pick ##1 ok |->
		true_out[0] == $past(cell_in[0].func_data)) else $error("functional capture wrong");
	a_scan_capture: assert property (ok && cell_in[0].test_path_pick ##1 ok |->
		true_out[0] == $past(cell_in[0].scan_data_in)) else $error("scan capture wrong");
	a_clear_forces: assert property (!async_clear_low |-> true_out == '0) else $error("clear not low");
	a_preset_forces: assert property (async_clear_low && !async_preset_low |-> true_out == '1)
		else $error("preset not high");
	a_inv_mirror: assert property (inverted_out == (BUFFERED ? ~true_out : '0)) else $error("inverse bad");
	a_flag_raise: assert property (both [*3] |=> illegal_seen) else $error("overlap not flagged");
	a_flag_sticky: assert property (illegal_seen && !rst |=> illegal_seen) else $error("flag dropped");
endmodule // scan_cell_chk

bind mux_scan_flip_flop_family scan_cell_chk #(.BUFFERED(BUFFERED), .WIDTH(WIDTH)) chk (.core_clk(core_clk),
	.rst(rst), .cell_in(cell_in), .async_clear_low(async_clear_low), .async_preset_low(async_preset_low),
	.true_out(true_out), .inverted_out(inverted_out), .illegal_seen(illegal_seen));

// >>> sim/mux_scan_flip_flop_family_tb.sv
// Self-checking bench for the mux-scan storage cell
`timescale 1ns/1ns

module mux_scan_flip_flop_family_tb;
	import scan_cell_pkg::*;
	// Clear is held through reset so the cell leaves it at a known level
	logic     core_clk = 1'b0, rst = 1'b1, d = 1'b0, s = 1'b0, p = 1'b0, cr = 1'b1, pr = 1'b0, ov = 1'b0;
	cell_in_t cin;
	logic     clr_n, pre_n, q, qn, flag;
	int       errors = 0;
	int       checks = 0;
	scan_env_model env (.func_bit(d), .scan_bit(s), .pick(p), .clear_req(cr), .preset_req(pr),
		.overlap_ok(ov), .cell_word(cin), .clear_low(clr_n), .preset_low(pre_n));
	mux_scan_flip_flop_family #(.BUFFERED(1'b1)) dut (.core_clk(core_clk), .rst(rst), .cell_in(cin),
		.async_clear_low(clr_n), .async_preset_low(pre_n), .true_out(q), .inverted_out(qn), .illegal_seen(flag));
	initial begin
		forever #5 core_clk = ~core_clk;
	end
	task automatic chk(input logic got, input logic exp);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic step;
		@(posedge core_clk);
		#1;
	endtask
	task automatic t_capture(input logic pk);
		for (int i = 0; i < 4; i++) begin
			p = pk;
			d = i[0];
			s = ~i[0];
			step;
			chk(q, pk ? ~i[0] : i[0]);
			chk(qn, pk ? i[0] : ~i[0]);
		end
		$display("capture pick=%h done", pk);
	endtask
	task automatic t_hold;
		p = 1'b0;
		d = 1'b1;
		step;
		#2 d = 1'b0;
		p = 1'b1;
		s = 1'b0;
		#2 chk(q, 1'b1);
		step;
		chk(q, 1'b0);
		$display("hold done");
	endtask
	task automatic t_async(input logic is_clr);
		p = 1'b0;
		d = is_clr;
		step;
		#2 cr = is_clr;
		pr = ~is_clr;
		#1 chk(q, ~is_clr);
		chk(qn, is_clr);
		step;
		chk(q, ~is_clr);
		cr = 1'b0;
		pr = 1'b0;
		step;
		chk(q, is_clr);
		$display("async clear=%h done", is_clr);
	endtask
	task automatic t_overlap;
		ov = 1'b1;
		cr = 1'b1;
		pr = 1'b1;
		repeat (4) step;
		chk(flag, 1'b1);
		chk(q, 1'b0);
		cr = 1'b0;
		pr = 1'b0;
		ov = 1'b0;
		rst = 1'b1;
		repeat (3) step;
		rst = 1'b0;
		chk(flag, 1'b0);
		$display("overlap done");
	endtask
	task automatic tally_and_finish;
		$display("checks=%0d errors=%0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge core_clk);
		#1 rst = 1'b0;
		cr = 1'b0;
		t_capture(1'b0);
		t_capture(1'b1);
		t_hold;
		t_async(1'b1);
		t_async(1'b0);
		t_overlap;
		tally_and_finish;
	end
	initial begin
		#3000;
		errors++;
		tally_and_finish;
	end
endmodule // mux_scan_flip_flop_family_tb
